// ==== fis_pkg.sv ====
/*
  Shared constants and types of the power transistor inspection sequencer.
  Assumes a single 10 MHz clock; control bits arrive as plain ports.
*/
// Operation
// (R1) Start only when start is written with unlock high; ignore start while running.
// (R2) Type C: resistors, wait, compare all off, all highs on, all lows on.
// (R3) Type C expected comparator word for steps 0 to 2 is 0555 hex.
// (R4) Mid-voltage resistors stay on for the whole of any running inspection.
// (R5) Type D applies one pattern latched at start, after the wait, then finishes.
// (R6) Type D phase with both sides requested drives both sides off.
// (R7) Type D does no comparison, only stores the six comparator outputs.
// (R8) Pre-driver controls come from the sequencer while running, else gate pins.
// (R9) Stop ends after the current step; step counter keeps last executed step.
// (R10) Stop in the final step is ignored; final is 6h for A/B, 2h for C/D.
// (R11) Clearing unlock returns to normal operation at once.
// (R12) While running, drain-source detection forced on, abnormality detection suppressed.
// (R13) Without mismatch, finish at step 7h for A/B, 3h for C.
// (R14) Running bit high for the whole inspection, low otherwise.
// (R15) Types A/B/C: first mismatch halts, sets error flag, keeps failing step.
// (R16) Store comparator outputs of the last performed step, failing step on mismatch.
// (R17) Error flag and saved word clear on new start or save-clear.
// (R18) Status read gives stored word when select low, live otherwise; select stores nothing.
// (R19) Controller drives all six gate inputs off before starting.
// (R20) Controller keeps unlock low during normal motor driving.
// (R21) Before Type C, controller stops pre-drivers through the alarm input.
// (R22) Controller waits for running low before reading results.
// (R23) Settling wait and step sampling point are parameters in clock cycles.
package fis_pkg;
  localparam int          CLK_NS        = 100;
  localparam int          SETTLE_NS     = 20000;
  localparam int          STEP_NS       = 50000;
  localparam int          SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          STEP_CYC      = (STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W         = 16;
  localparam int          STEP_W        = 4;
  localparam int          WORD_W        = 16;
  localparam int          CH_N          = 6;
  localparam int          CMP_STRIDE    = 2;
  localparam logic [1:0]  TYPE_A        = 2'h0;
  localparam logic [1:0]  TYPE_B        = 2'h1;
  localparam logic [1:0]  TYPE_C        = 2'h2;
  localparam logic [1:0]  TYPE_D        = 2'h3;
  localparam logic [3:0]  FINAL_AB      = 4'h6;
  localparam logic [3:0]  FINAL_CD      = 4'h2;
  localparam logic [3:0]  DONE_AB       = 4'h7;
  localparam logic [3:0]  DONE_C        = 4'h3;
  localparam logic [3:0]  STEP_RESET    = 4'h0;
  localparam logic [15:0] EXPECT_C      = 16'h0555;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [5:0]  DRIVE_OFF     = 6'h00;
  localparam logic [5:0]  DRIVE_HIGHS   = 6'h2A;
  localparam logic [5:0]  DRIVE_LOWS    = 6'h15;
  typedef enum logic [1:0] {FIS_IDLE, FIS_SETTLE, FIS_STEP} fis_state_t;
endpackage

// ==== fis_sync.sv ====
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to mclk.
*/
`timescale 1ns/10ps
module fis_sync #(
  parameter int W = 6
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Pins in, synchronised out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= '0;
      pin_sync <= '0;
    end else if (ce) begin
      meta     <= pin_in;
      pin_sync <= meta;
    end
  end
endmodule // fis_sync

// ==== fis_step_drive.sv ====
/*
  Drive pattern of the current inspection step, order {uh,ul,vh,vl,wh,wl}.
  Assumes step and latched pattern are stable while a step runs.
*/
`timescale 1ns/10ps
module fis_step_drive (
  // Step selection
  input  wire logic [1:0] test_type,
  input  wire logic [3:0] step,
  input  wire logic [5:0] pattern,
  // Resulting pre-driver pattern
  output logic      [5:0] drive
);
  logic [5:0] d_safe;

  // A phase asking for both sides would short the rail
  for (genvar p = 0; p < 3; p++) begin : g_phase
    assign d_safe[2*p+1] = pattern[2*p+1] & ~pattern[2*p]; // R6
    assign d_safe[2*p]   = pattern[2*p] & ~pattern[2*p+1]; // R6
  end

  always_comb begin
    drive = fis_pkg::DRIVE_OFF;
    if (test_type == fis_pkg::TYPE_D) begin
      drive = d_safe; // R5
    end else if (step == 4'h1) begin
      drive = fis_pkg::DRIVE_HIGHS; // R2
    end else if (step == 4'h2) begin
      drive = fis_pkg::DRIVE_LOWS; // R2
    end
  end
endmodule // fis_step_drive

// ==== fis_sequencer.sv ====
/*
  Automatic inspection sequencer for the external bridge transistors, Types C and D.
  Assumes comparator inputs come from the on-chip noise filter on mclk and the
  gate inputs are device pins; control bits are plain ports, start/stop pulses.
*/
`timescale 1ns/10ps
module fis_sequencer #(
  parameter int SETTLE_CYC = fis_pkg::SETTLE_CYC,
  parameter int STEP_CYC   = fis_pkg::STEP_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Control bits
  input  wire logic        unlock,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [1:0]  test_type,
  input  wire logic [5:0]  inspection_pattern_config,
  input  wire logic        saved_result_clear,
  input  wire logic        comparator_read_select,
  // Gate control pins
  input  wire logic        gate_in_u_high,
  input  wire logic        gate_in_u_low,
  input  wire logic        gate_in_v_high,
  input  wire logic        gate_in_v_low,
  input  wire logic        gate_in_w_high,
  input  wire logic        gate_in_w_low,
  // Filtered drain-source comparators
  input  wire logic        cmp_phase_u_high,
  input  wire logic        cmp_phase_u_low,
  input  wire logic        cmp_phase_v_high,
  input  wire logic        cmp_phase_v_low,
  input  wire logic        cmp_phase_w_high,
  input  wire logic        cmp_phase_w_low,
  // Status
  output logic             running,
  output logic             test_error,
  output logic [3:0]       inspection_step_counter,
  output logic [15:0]      drain_source_comparator_status,
  // Pre-driver and detector control
  output logic             pre_u_high,
  output logic             pre_u_low,
  output logic             pre_v_high,
  output logic             pre_v_low,
  output logic             pre_w_high,
  output logic             pre_w_low,
  output logic             mid_res_on,
  output logic             vds_det_force,
  output logic             vds_fault_mask
);
  localparam int CNT_W = fis_pkg::CNT_W;
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] STEP_LAST   = CNT_W'(STEP_CYC - 1);

  initial begin
    if (SETTLE_CYC < 1 || SETTLE_CYC > 65536 || STEP_CYC < 1 || STEP_CYC > 65536) begin
      $error("fis_sequencer: cycle counts out of range");
    end
  end

  fis_pkg::fis_state_t state;
  fis_pkg::fis_state_t next_state;
  logic [CNT_W-1:0]    cnt;
  logic [1:0]          run_type;
  logic [5:0]          pattern_lat;
  logic                stop_pend;
  logic [15:0]         saved_comparator_word;
  logic [15:0]         live_word;
  logic [5:0]          cmp_vec;
  logic [5:0]          gate_sync;
  logic [5:0]          step_drive;
  logic                start_ok;
  logic                sample;
  logic                mismatch;
  logic                final_step;
  logic                finish;

  fis_sync #(.W(6)) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .ce       (ce),
    .pin_in   ({gate_in_u_high, gate_in_u_low, gate_in_v_high,
                gate_in_v_low, gate_in_w_high, gate_in_w_low}),
    .pin_sync (gate_sync)
  );

  fis_step_drive u_drive (
    .test_type (run_type),
    .step      (inspection_step_counter),
    .pattern   (pattern_lat),
    .drive     (step_drive)
  );

  // Comparators sit on even bits, odd bits read zero
  assign cmp_vec = {cmp_phase_u_high, cmp_phase_u_low, cmp_phase_v_high,
                    cmp_phase_v_low, cmp_phase_w_high, cmp_phase_w_low};
  for (genvar i = 0; i < fis_pkg::CH_N; i++) begin : g_word
    assign live_word[fis_pkg::CMP_STRIDE*i]   = cmp_vec[i];
    assign live_word[fis_pkg::CMP_STRIDE*i+1] = 1'b0;
  end
  assign live_word[15:12] = 4'h0;

  // Types A and B are not built here, so their start is not taken
  assign start_ok   = ce && unlock && start && state == fis_pkg::FIS_IDLE &&
                      (test_type == fis_pkg::TYPE_C || test_type == fis_pkg::TYPE_D); // R1
  assign sample     = ce && state == fis_pkg::FIS_STEP && cnt == STEP_LAST; // R23
  assign mismatch   = sample && run_type == fis_pkg::TYPE_C &&
                      live_word != fis_pkg::EXPECT_C; // R3 R15
  assign final_step = inspection_step_counter == fis_pkg::FINAL_CD; // R10
  assign finish     = sample && (mismatch || final_step || stop_pend); // R9 R15

  always_comb begin
    next_state = state;
    if (!unlock) begin
      next_state = fis_pkg::FIS_IDLE; // R11
    end else if (ce) begin
      case (state)
        fis_pkg::FIS_IDLE: begin
          if (start_ok) begin
            next_state = fis_pkg::FIS_SETTLE; // R1
          end
        end
        fis_pkg::FIS_SETTLE: begin
          if (cnt == SETTLE_LAST) begin
            next_state = fis_pkg::FIS_STEP; // R23
          end
        end
        fis_pkg::FIS_STEP: begin
          if (finish) begin
            next_state = fis_pkg::FIS_IDLE;
          end
        end
        default: next_state = fis_pkg::FIS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= fis_pkg::FIS_IDLE;
      running <= 1'b0;
    end else begin
      state   <= next_state;
      running <= next_state != fis_pkg::FIS_IDLE; // R14
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (ce) begin
      if (next_state != state || sample) begin
        cnt <= '0;
      end else if (state != fis_pkg::FIS_IDLE) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // Pattern and type frozen at start so later writes do not disturb the run
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_type    <= fis_pkg::TYPE_C;
      pattern_lat <= fis_pkg::DRIVE_OFF;
    end else if (start_ok) begin
      run_type    <= test_type;
      pattern_lat <= inspection_pattern_config; // R5
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      inspection_step_counter <= fis_pkg::STEP_RESET;
    end else if (start_ok) begin
      inspection_step_counter <= (test_type == fis_pkg::TYPE_D) ?
                                 fis_pkg::FINAL_CD : fis_pkg::STEP_RESET; // R5
    end else if (sample && !mismatch && unlock) begin
      if (final_step && run_type == fis_pkg::TYPE_C) begin
        inspection_step_counter <= fis_pkg::DONE_C; // R13
      end else if (!final_step && !stop_pend) begin
        inspection_step_counter <= inspection_step_counter + 4'h1; // R2
      end
    end
  end

  // Stop is only remembered outside the final step
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stop_pend <= 1'b0;
    end else if (ce) begin
      if (start_ok || state == fis_pkg::FIS_IDLE) begin
        stop_pend <= 1'b0;
      end else if (stop && !final_step) begin
        stop_pend <= 1'b1; // R9 R10
      end
    end
  end

  // Hardware set wins over a same-cycle clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      test_error <= 1'b0;
    end else if (mismatch && unlock) begin
      test_error <= 1'b1; // R15
    end else if (start_ok || (ce && saved_result_clear)) begin
      test_error <= 1'b0; // R17
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      saved_comparator_word <= fis_pkg::WORD_RESET;
    end else if (sample && unlock) begin
      saved_comparator_word <= live_word; // R7 R16
    end else if (start_ok || (ce && saved_result_clear)) begin
      saved_comparator_word <= fis_pkg::WORD_RESET; // R17
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drain_source_comparator_status <= fis_pkg::WORD_RESET;
    end else if (ce) begin
      drain_source_comparator_status <= comparator_read_select ?
                                        live_word : saved_comparator_word; // R18
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {pre_u_high, pre_u_low, pre_v_high, pre_v_low, pre_w_high, pre_w_low} <= 6'h00;
    end else if (next_state == fis_pkg::FIS_IDLE) begin
      {pre_u_high, pre_u_low, pre_v_high, pre_v_low, pre_w_high, pre_w_low} <= gate_sync; // R8
    end else if (state == fis_pkg::FIS_STEP) begin
      {pre_u_high, pre_u_low, pre_v_high, pre_v_low, pre_w_high, pre_w_low} <= step_drive; // R8
    end else begin
      {pre_u_high, pre_u_low, pre_v_high, pre_v_low, pre_w_high, pre_w_low} <= 6'h00;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mid_res_on     <= 1'b0;
      vds_det_force  <= 1'b0;
      vds_fault_mask <= 1'b0;
    end else begin
      mid_res_on     <= next_state != fis_pkg::FIS_IDLE; // R4
      vds_det_force  <= next_state != fis_pkg::FIS_IDLE; // R12
      vds_fault_mask <= next_state != fis_pkg::FIS_IDLE; // R12
    end
  end

  a_unlock_abort: assert property ( // R11
    @(posedge mclk) disable iff (!rst_n) !unlock |=> !running && !mid_res_on)
    else $error("unlock low did not end the inspection");

  a_start_taken: assert property ( // R1
    @(posedge mclk) disable iff (!rst_n)
    (ce && unlock && start && !running && state == fis_pkg::FIS_IDLE &&
     test_type == fis_pkg::TYPE_C) |=> running && !test_error)
    else $error("valid start not taken");

  a_busy_start: assert property ( // R1
    @(posedge mclk) disable iff (!rst_n)
    (state == fis_pkg::FIS_STEP && start && !sample && unlock) |=>
    inspection_step_counter == $past(inspection_step_counter))
    else $error("start during inspection restarted it");

  a_run_outputs: assert property ( // R4
    @(posedge mclk) disable iff (!rst_n)
    running |-> mid_res_on && vds_det_force && vds_fault_mask)
    else $error("resistors or detector mode off while running");

  a_mismatch_halt: assert property ( // R15
    @(posedge mclk) disable iff (!rst_n)
    (mismatch && unlock) |=> test_error && !running &&
    inspection_step_counter == $past(inspection_step_counter) &&
    saved_comparator_word == $past(live_word))
    else $error("mismatch did not halt with step kept");

  a_c_complete: assert property ( // R13
    @(posedge mclk) disable iff (!rst_n)
    (sample && unlock && !mismatch && run_type == fis_pkg::TYPE_C && final_step) |=>
    inspection_step_counter == fis_pkg::DONE_C && !running)
    else $error("type C did not finish at step three");

  a_stop_hold: assert property ( // R9
    @(posedge mclk) disable iff (!rst_n)
    (sample && unlock && stop_pend && !mismatch && !final_step) |=>
    !running && inspection_step_counter == $past(inspection_step_counter))
    else $error("stop did not end after the step");

  a_d_conflict: assert property ( // R6
    @(posedge mclk) disable iff (!rst_n)
    (state == fis_pkg::FIS_STEP && next_state == fis_pkg::FIS_STEP &&
     run_type == fis_pkg::TYPE_D && pattern_lat[5] && pattern_lat[4]) |=>
    !pre_u_high && !pre_u_low)
    else $error("both sides of phase u driven");

  a_clear_saved: assert property ( // R17
    @(posedge mclk) disable iff (!rst_n)
    (ce && saved_result_clear && !sample) |=> !test_error && saved_comparator_word == 16'h0000)
    else $error("save-clear left results");
endmodule // fis_sequencer

// ==== fis_bridge_model.sv ====
/*
  Behavioural model of the external transistor bridge seen through the
  pre-drivers and the on-chip comparator filter.
  Assumes the testbench picks one drive pattern in which a fault shows.
*/
`timescale 1ns/10ps
module fis_bridge_model (
  // Clock
  input  wire logic       mclk,
  // Pre-driver pattern {uh,ul,vh,vl,wh,wl}
  input  wire logic [5:0] drive,
  // Fault injection and answer speed
  input  wire logic [5:0] fault_drive,
  input  wire logic [5:0] fault_bits,
  input  wire logic       slow,
  // Filtered comparator outputs {uh,ul,vh,vl,wh,wl}
  output logic      [5:0] cmp
);
  logic [5:0] now_cmp;
  logic [5:0] held_cmp;

  // Healthy bridge reads all comparators high; a fault bites only in its pattern
  assign now_cmp = (drive == fault_drive) ? ~fault_bits : 6'h3F;

  // Slow answer lags the drive by one cycle, still inside a step
  always_ff @(posedge mclk) begin
    held_cmp <= now_cmp;
  end

  assign cmp = slow ? held_cmp : now_cmp;
endmodule // fis_bridge_model

// ==== fis_sequencer_tb_top.sv ====
/*
  Self-checking testbench of the inspection sequencer, Types C and D.
  Assumes short settle and step counts and a healthy bridge unless a fault is set.
*/
`timescale 1ns/10ps
module fis_sequencer_tb_top;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        unlock = 1'b0;
  logic        start = 1'b0;
  logic        stop = 1'b0;
  logic [1:0]  test_type = 2'h2;
  logic [5:0]  pattern_cfg = 6'h00;
  logic        save_clear = 1'b0;
  logic        read_select = 1'b0;
  logic        ce = 1'b1;
  logic [5:0]  gate_pins = 6'h00;
  logic [5:0]  fault_drive = 6'h3F;
  logic [5:0]  fault_bits = 6'h00;
  logic        slow = 1'b1;
  logic [5:0]  cmp;
  logic [5:0]  drive;
  logic        running;
  logic        test_error;
  logic [3:0]  step;
  logic [15:0] status;
  logic        mid_res_on;
  logic        det_force;
  logic        fault_mask;
  logic [63:0] seen_mask = 64'h0;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #50 mclk = ~mclk;

  fis_sequencer #(.SETTLE_CYC(4), .STEP_CYC(4)) fis_sequencer_inst (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .unlock(unlock), .start(start), .stop(stop),
    .test_type(test_type), .inspection_pattern_config(pattern_cfg),
    .saved_result_clear(save_clear), .comparator_read_select(read_select),
    .gate_in_u_high(gate_pins[5]), .gate_in_u_low(gate_pins[4]),
    .gate_in_v_high(gate_pins[3]), .gate_in_v_low(gate_pins[2]),
    .gate_in_w_high(gate_pins[1]), .gate_in_w_low(gate_pins[0]),
    .cmp_phase_u_high(cmp[5]), .cmp_phase_u_low(cmp[4]), .cmp_phase_v_high(cmp[3]),
    .cmp_phase_v_low(cmp[2]), .cmp_phase_w_high(cmp[1]), .cmp_phase_w_low(cmp[0]),
    .running(running), .test_error(test_error), .inspection_step_counter(step),
    .drain_source_comparator_status(status),
    .pre_u_high(drive[5]), .pre_u_low(drive[4]), .pre_v_high(drive[3]),
    .pre_v_low(drive[2]), .pre_w_high(drive[1]), .pre_w_low(drive[0]),
    .mid_res_on(mid_res_on), .vds_det_force(det_force), .vds_fault_mask(fault_mask)
  );

  fis_bridge_model fis_bridge_model_inst (
    .mclk(mclk), .drive(drive), .fault_drive(fault_drive), .fault_bits(fault_bits),
    .slow(slow), .cmp(cmp)
  );

  // Record every pattern the sequencer applies while running
  always @(posedge mclk) begin
    if (running === 1'b1) seen_mask[drive] <= 1'b1;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask

  function automatic logic [15:0] spread(input logic [5:0] b);
    spread = 16'h0000;
    for (int i = 0; i < 6; i++) spread[2*i] = b[i];
  endfunction

  task automatic pulse_start(input logic [1:0] kind);
    test_type = kind;
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask

  task automatic do_run(input logic [1:0] kind);
    int n;
    n = 0;
    seen_mask = 64'h0;
    pulse_start(kind);
    while (running !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    check(running, 1'b1);
  endtask

  task automatic wait_end();
    int n;
    n = 0;
    while (running === 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    check(running, 1'b0);
    // Status register trails the saved word by one cycle
    tick(1);
  endtask

  task automatic wait_step(input logic [3:0] s);
    int n;
    n = 0;
    while (step !== s && n < 100) begin
      tick(1);
      n++;
    end
  endtask

  task automatic t_refused();
    unlock = 1'b0;
    pulse_start(2'h2);
    tick(3);
    check(running, 1'b0);
    unlock = 1'b1;
  endtask

  task automatic t_gate_path();
    gate_pins = 6'h20;
    tick(4);
    check(drive, 6'h20);
    gate_pins = 6'h1F;
    tick(4);
    check(drive, 6'h1F);
    gate_pins = 6'h00;
    tick(4);
  endtask

  task automatic t_ce();
    do_run(2'h2);
    wait_step(4'h1);
    ce = 1'b0;
    tick(20);
    check({running, step}, 5'h11);
    ce = 1'b1;
    wait_end();
    check(step, 4'h3);
  endtask

  task automatic t_c_fail();
    fault_drive = 6'h2A;
    fault_bits = 6'h20;
    do_run(2'h2);
    wait_end();
    check(test_error, 1'b1);
    check(step, 4'h1);
    check(status, 16'h0155);
    fault_drive = 6'h3F;
  endtask

  task automatic t_c_pass();
    do_run(2'h2);
    check(test_error, 1'b0);
    check({mid_res_on, det_force, fault_mask}, 3'h7);
    tick(2);
    pulse_start(2'h2);
    check(mid_res_on, 1'b1);
    wait_end();
    check(step, 4'h3);
    check(test_error, 1'b0);
    check(status, spread(6'h3F));
    check(seen_mask, 64'h1 | (64'h1 << 6'h2A) | (64'h1 << 6'h15));
  endtask

  task automatic t_select();
    fault_drive = 6'h00;
    fault_bits = 6'h03;
    read_select = 1'b1;
    tick(2);
    check(status, 16'h0550);
    read_select = 1'b0;
    tick(2);
    check(status, 16'h0555);
    fault_drive = 6'h3F;
  endtask

  task automatic t_clear();
    save_clear = 1'b1;
    tick(1);
    save_clear = 1'b0;
    tick(1);
    check(test_error, 1'b0);
    check(status, 16'h0000);
  endtask

  task automatic t_stop();
    do_run(2'h2);
    wait_step(4'h1);
    stop = 1'b1;
    tick(1);
    stop = 1'b0;
    wait_end();
    check(step, 4'h1);
    do_run(2'h2);
    wait_step(4'h2);
    stop = 1'b1;
    tick(1);
    stop = 1'b0;
    wait_end();
    check(step, 4'h3);
  endtask

  task automatic t_unlock();
    do_run(2'h2);
    wait_step(4'h1);
    unlock = 1'b0;
    tick(2);
    check({running, mid_res_on, det_force}, 3'h0);
    check(drive, 6'h00);
    unlock = 1'b1;
  endtask

  task automatic t_type_d();
    pattern_cfg = 6'b110110;
    fault_drive = 6'h06;
    fault_bits = 6'h01;
    slow = 1'b0;
    do_run(2'h3);
    pattern_cfg = 6'h00;
    wait_end();
    check(step, 4'h2);
    check(test_error, 1'b0);
    check(status, 16'h0554);
    check(seen_mask, 64'h1 | (64'h1 << 6'h06));
    slow = 1'b1;
    fault_drive = 6'h3F;
  endtask

  initial begin
    tick(12);
    rst_n = 1'b1;
    tick(1);
    check({running, test_error, step, status}, 22'h0);
    t_refused();
    t_gate_path();
    t_c_fail();
    t_c_pass();
    t_select();
    t_c_fail();
    t_clear();
    t_stop();
    t_ce();
    t_unlock();
    t_type_d();
    report_and_stop();
  end
endmodule // fis_sequencer_tb_top
